// ---- rtl/dfa_pkg.sv ----
package dfa_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int BLOCK_BYTES = 1024;
  localparam int BLOCK_LSB = 10;
  localparam int READ_WAITS = 3;
  localparam int READ_TOTAL = 1 + READ_WAITS;
  localparam int PROG_CYCLES = 8;
  localparam int ERASE_CYCLES = 64;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_CPU = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  typedef enum logic [1:0] {OP_PROG, OP_ERASE} dfa_op_t;
endpackage

// ---- rtl/dfa_wait_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module dfa_wait_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic done
);
  logic [WIDTH-1:0] cnt_reg;
  logic run_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else if (load) begin
      cnt_reg <= count;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - WIDTH'(1);
      if (cnt_reg == WIDTH'(1)) begin
        run_reg <= 1'b0;
      end
    end
  end
  assign done = run_reg && (cnt_reg == WIDTH'(1));
endmodule
`default_nettype wire

// ---- rtl/dfa_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RULE_01) rewrites come from cpu side or from an external programmer port
// (RULE_02) each program operation writes exactly one byte
// (RULE_03) erase clears one whole 1 KB block, never less
// (RULE_04) cpu reads are byte wide, one cycle plus three wait cycles
// (RULE_05) software must not write the access control register during a rewrite
// (RULE_06) no halt or stop entry while a rewrite is in progress
// (RULE_07) a busy flag shows an active rewrite and blocks control writes, low power
module dfa_gate #(
  parameter int ADDR_W = dfa_pkg::ADDR_W,
  parameter int DEPTH = 4096
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cpuRdReq,
  input wire logic [ADDR_W-1:0] cpuAddr,
  output logic [7:0] cpuRdData,
  output logic cpuRdValid,
  output logic cpuRdReady,
  input wire logic cpuWrReq,
  input wire logic cpuWrOp,
  input wire logic [ADDR_W-1:0] cpuWrAddr,
  input wire logic [7:0] cpuWrData,
  input wire logic extWrReq,
  input wire logic extWrOp,
  input wire logic [ADDR_W-1:0] extWrAddr,
  input wire logic [7:0] extWrData,
  output logic rewriteAccept,
  output logic rewriteDone,
  input wire logic ctlWrReq,
  input wire logic [7:0] ctlWrData,
  output logic [7:0] dataFlashAccessControl,
  output logic ctlWrRefused,
  input wire logic lowPowerReq,
  output logic lowPowerGrant,
  output logic rewriteBusy
);
  // mem is indexed by a clog2-wide address, so only power-of-two depths are served
  if (DEPTH < dfa_pkg::BLOCK_BYTES || DEPTH % dfa_pkg::BLOCK_BYTES != 0 ||
      (DEPTH & (DEPTH - 1)) != 0 || DEPTH > (1 << ADDR_W)) begin : g_depth_check
    $error("DEPTH must be a power-of-two count of blocks that fits the address");
  end
  localparam int AW = $clog2(DEPTH);
  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE} dfa_state_t;

  logic [7:0] mem [DEPTH];
  dfa_state_t state_reg;
  logic [AW-1:0] opAddr_reg;
  logic [7:0] opData_reg;
  logic [2:0] rdCnt_reg;
  logic [AW-1:0] rdAddr_reg;
  logic opDone;
  logic opLoad;
  logic [7:0] opCount;
  logic takeCpu;
  logic takeExt;
  logic reqOp;
  logic [ADDR_W-1:0] reqAddr;
  logic [7:0] reqData;

  function automatic logic [AW-1:0] blockBase(input logic [AW-1:0] a);
    blockBase = {a[AW-1:dfa_pkg::BLOCK_LSB], {dfa_pkg::BLOCK_LSB{1'b0}}};
  endfunction

  // external programmer wins ties: it owns the part during serial programming
  assign takeExt = (state_reg == ST_IDLE) && extWrReq; // [RULE_01]
  assign takeCpu = (state_reg == ST_IDLE) && !extWrReq && cpuWrReq; // [RULE_01]
  assign reqOp = takeExt ? extWrOp : cpuWrOp;
  assign reqAddr = takeExt ? extWrAddr : cpuWrAddr;
  assign reqData = takeExt ? extWrData : cpuWrData;
  assign opLoad = takeExt || takeCpu;
  assign opCount = (reqOp == 1'b1) ? 8'(dfa_pkg::ERASE_CYCLES) : 8'(dfa_pkg::PROG_CYCLES);

  dfa_wait_counter #(.WIDTH(8)) u_opTimer (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(opLoad),
    .count(opCount),
    .done(opDone)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      opAddr_reg <= '0;
      opData_reg <= 8'h00;
    end else if (opLoad) begin
      state_reg <= reqOp ? ST_ERASE : ST_PROG;
      opAddr_reg <= reqOp ? blockBase(reqAddr[AW-1:0]) : reqAddr[AW-1:0]; // [RULE_03]
      opData_reg <= reqData;
    end else if (state_reg == ST_ERASE && !opDone) begin
      opAddr_reg <= opAddr_reg + AW'(1);
    end else if (opDone) begin
      state_reg <= ST_IDLE;
    end
  end

  // erase steps opAddr_reg one byte per cycle but writes nothing while it walks;
  // the whole block is cleared in the closing cycle by a loop over the block
  always_ff @(posedge clk_sys) begin
    if (state_reg == ST_PROG && opDone) begin
      mem[opAddr_reg] <= opData_reg; // [RULE_02]
    end else if (state_reg == ST_ERASE && opDone) begin
      for (int i = 0; i < dfa_pkg::BLOCK_BYTES; i++) begin
        mem[{opAddr_reg[AW-1:dfa_pkg::BLOCK_LSB], dfa_pkg::BLOCK_LSB'(i)}]
          <= dfa_pkg::ERASED_BYTE; // [RULE_03]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rewriteAccept <= 1'b0;
      rewriteDone <= 1'b0;
      rewriteBusy <= 1'b0;
    end else begin
      rewriteAccept <= opLoad;
      rewriteDone <= opDone;
      rewriteBusy <= opLoad || (state_reg != ST_IDLE && !opDone); // [RULE_07]
    end
  end

  // read: request cycle plus three waits, data on the fourth edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdCnt_reg <= 3'h0;
      rdAddr_reg <= '0;
      cpuRdValid <= 1'b0;
      cpuRdData <= 8'h00;
      cpuRdReady <= 1'b0;
    end else begin
      cpuRdValid <= 1'b0;
      cpuRdReady <= (rdCnt_reg == 3'h0) && !cpuRdReq;
      if (rdCnt_reg == 3'h0 && cpuRdReq) begin
        rdCnt_reg <= 3'(dfa_pkg::READ_TOTAL - 1); // [RULE_04]
        rdAddr_reg <= cpuAddr[AW-1:0];
      end else if (rdCnt_reg != 3'h0) begin
        rdCnt_reg <= rdCnt_reg - 3'h1;
        if (rdCnt_reg == 3'h1) begin
          cpuRdValid <= 1'b1; // [RULE_04]
          cpuRdData <= mem[rdAddr_reg];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dataFlashAccessControl <= 8'h00;
      ctlWrRefused <= 1'b0;
    end else begin
      // opLoad covers the take cycle, before busy has risen
      ctlWrRefused <= ctlWrReq && (rewriteBusy || opLoad); // [RULE_05]
      if (ctlWrReq && !rewriteBusy && !opLoad) begin
        dataFlashAccessControl <= ctlWrData; // [RULE_05]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lowPowerGrant <= 1'b0;
    end else begin
      lowPowerGrant <= lowPowerReq && !rewriteBusy && !opLoad; // [RULE_06]
    end
  end

  property p_read_latency;
    @(posedge clk_sys) disable iff (rst)
    (rdCnt_reg == 3'h0 && cpuRdReq) |=> !cpuRdValid [*3] ##1 cpuRdValid;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read latency wrong"); // [RULE_04]

  property p_ctl_hold;
    @(posedge clk_sys) disable iff (rst)
    (ctlWrReq && rewriteBusy) |=> $stable(dataFlashAccessControl) && ctlWrRefused;
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("control changed while busy"); // [RULE_05]

  property p_no_lp;
    @(posedge clk_sys) disable iff (rst)
    rewriteBusy |=> !lowPowerGrant;
  endproperty
  a_no_lp: assert property (p_no_lp) else $error("low power granted while busy"); // [RULE_06]

  property p_busy_prog;
    @(posedge clk_sys) disable iff (rst)
    (opLoad && !reqOp) |=> rewriteBusy [*8] ##1 rewriteDone;
  endproperty
  a_busy_prog: assert property (p_busy_prog) else $error("program timing wrong"); // [RULE_07]

  property p_prog_byte;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_PROG && opDone) |=> mem[$past(opAddr_reg)] == $past(opData_reg);
  endproperty
  a_prog_byte: assert property (p_prog_byte) else $error("byte not programmed"); // [RULE_02]

  property p_erase_base;
    @(posedge clk_sys) disable iff (rst)
    (opLoad && reqOp) |=> opAddr_reg[dfa_pkg::BLOCK_LSB-1:0] == '0;
  endproperty
  a_erase_base: assert property (p_erase_base) else $error("erase not block aligned"); // [RULE_03]

  property p_ext_first;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == ST_IDLE && extWrReq) |=> rewriteAccept && rewriteBusy;
  endproperty
  a_ext_first: assert property (p_ext_first) else $error("external request not taken"); // [RULE_01]

  property p_done_idle;
    @(posedge clk_sys) disable iff (rst)
    rewriteDone |-> !rewriteBusy;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy after done"); // [RULE_07]

  c_read: cover property (@(posedge clk_sys) disable iff (rst) cpuRdValid);
  c_erase: cover property (@(posedge clk_sys) disable iff (rst) state_reg == ST_ERASE && opDone);
  c_refuse: cover property (@(posedge clk_sys) disable iff (rst) ctlWrRefused);
endmodule
`default_nettype wire

// ---- bench/dfa_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dfa_core_model (
  input wire logic clk_sys,
  output logic cpuRdReq,
  output logic [15:0] cpuAddr,
  input wire logic [7:0] cpuRdData,
  input wire logic cpuRdValid,
  output logic cpuWrReq,
  output logic cpuWrOp,
  output logic [15:0] cpuWrAddr,
  output logic [7:0] cpuWrData,
  output logic extWrReq,
  output logic extWrOp,
  output logic [15:0] extWrAddr,
  output logic [7:0] extWrData,
  input wire logic rewriteAccept,
  input wire logic rewriteDone,
  output logic ctlWrReq,
  output logic [7:0] ctlWrData,
  input wire logic ctlWrRefused,
  output logic lowPowerReq,
  input wire logic lowPowerGrant
);
  int cyc = 0;
  int t0 = 0;
  initial {cpuRdReq, cpuAddr, cpuWrReq, cpuWrOp, cpuWrAddr, cpuWrData, extWrReq, extWrOp,
    extWrAddr, extWrData, ctlWrReq, ctlWrData, lowPowerReq} = '0;
  // counted on the rising edge so negedge readers never race it
  always @(posedge clk_sys) cyc++;
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output int n);
    @(negedge clk_sys);
    cpuRdReq = 1'b1;
    cpuAddr = a;
    n = 0;
    do begin
      @(negedge clk_sys);
      cpuRdReq = 1'b0;
      n++;
    end while (!cpuRdValid && n < 9);
    d = cpuRdData;
    cpuAddr = ~a;
  endtask
  // x selects the external programmer port; request held until accepted
  task automatic wr(input logic x, input logic op, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    if (x) {extWrReq, extWrOp, extWrAddr, extWrData} = {1'b1, op, a, d};
    else {cpuWrReq, cpuWrOp, cpuWrAddr, cpuWrData} = {1'b1, op, a, d};
    for (int i = 0; i < 9 && !rewriteAccept; i++) @(negedge clk_sys);
    t0 = cyc;
    {extWrReq, cpuWrReq} = 2'b00;
    {extWrData, cpuWrData} = ~{d, d};
  endtask
  task automatic fin(output int n);
    for (int i = 0; i < 99 && !rewriteDone; i++) @(negedge clk_sys);
    n = cyc - t0;
  endtask
  task automatic ctl(input logic [7:0] v, output logic r);
    @(negedge clk_sys);
    ctlWrReq = 1'b1;
    ctlWrData = v;
    @(negedge clk_sys);
    ctlWrReq = 1'b0;
    ctlWrData = ~v;
    r = ctlWrRefused;
  endtask
  task automatic lp(input logic v, output logic g);
    @(negedge clk_sys);
    lowPowerReq = v;
    repeat (2) @(negedge clk_sys);
    g = lowPowerGrant;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [15:0] CORNER [4] = '{16'h0000, 16'h03FF, 16'h0400, 16'h07FF};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cpuRdReq, cpuRdValid, cpuWrReq, cpuWrOp, extWrReq, extWrOp, rewriteAccept, cpuRdReady;
  logic rewriteDone, ctlWrReq, ctlWrRefused, lowPowerReq, lowPowerGrant, rewriteBusy, r;
  logic [15:0] cpuAddr, cpuWrAddr, extWrAddr, a;
  logic [7:0] cpuRdData, cpuWrData, extWrData, ctlWrData, dataFlashAccessControl, d;
  logic [15:0] rnd = 16'h4EB8;
  logic [7:0] expMem [int];
  int nErrors = 0;
  int testsRun = 0;
  int n;
  always #5 clk_sys = ~clk_sys;
  dfa_gate i_dfa_gate (.clk_sys, .rst, .cpuRdReq, .cpuAddr, .cpuRdData, .cpuRdValid,
    .cpuRdReady, .cpuWrReq, .cpuWrOp, .cpuWrAddr, .cpuWrData, .extWrReq, .extWrOp,
    .extWrAddr, .extWrData, .rewriteAccept, .rewriteDone, .ctlWrReq, .ctlWrData,
    .dataFlashAccessControl, .ctlWrRefused, .lowPowerReq, .lowPowerGrant, .rewriteBusy);
  dfa_core_model i_dfa_core_model (.clk_sys, .cpuRdReq, .cpuAddr, .cpuRdData, .cpuRdValid,
    .cpuWrReq, .cpuWrOp, .cpuWrAddr, .cpuWrData, .extWrReq, .extWrOp, .extWrAddr,
    .extWrData, .rewriteAccept, .rewriteDone, .ctlWrReq, .ctlWrData, .ctlWrRefused,
    .lowPowerReq, .lowPowerGrant);
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // unprogrammed bytes of an erased block read back as all ones
  function automatic logic [7:0] ev(input int ad);
    return expMem.exists(ad) ? expMem[ad] : 8'hFF;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    testsRun++;
    if (got !== want) begin
      nErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic summarize();
    $display("errors=%0d checks=%0d", nErrors, testsRun);
    if (nErrors == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    rnd = lfsr(rnd);
    i_dfa_core_model.wr(1'b1, 1'b1, {6'h01, rnd[9:0]}, rnd[15:8]);
    chk(rewriteBusy, 1);
    i_dfa_core_model.ctl(8'h5A, r);
    chk(r, 1);
    chk(dataFlashAccessControl, 0);
    i_dfa_core_model.lp(1'b1, r);
    chk(r, 0);
    i_dfa_core_model.lp(1'b0, r);
    i_dfa_core_model.fin(n);
    chk(n, 64);
    i_dfa_core_model.wr(1'b0, 1'b1, {6'h00, rnd[9:0]}, 8'h00);
    i_dfa_core_model.fin(n);
    chk(n, 64);
    chk(rewriteBusy, 0);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      a = (i < 4) ? CORNER[i] : {5'h00, rnd[10:0]};
      i_dfa_core_model.wr(i[0], 1'b0, a, rnd[15:8]);
      expMem[a] = rnd[15:8];
      i_dfa_core_model.fin(n);
      chk(n, 8);
    end
    // the lsb neighbour stays inside the erased block and must stay erased
    foreach (expMem[k]) begin
      for (int j = 0; j < 2; j++) begin
        a = k[15:0] ^ j[15:0];
        i_dfa_core_model.rd(a, d, n);
        chk(n, 4);
        chk(d, ev(a));
        chk(cpuRdReady, 0);
        @(negedge clk_sys);
        chk(cpuRdReady, 1);
      end
    end
    rnd = lfsr(rnd);
    i_dfa_core_model.ctl(rnd[7:0], r);
    chk(r, 0);
    chk(dataFlashAccessControl, rnd[7:0]);
    i_dfa_core_model.lp(1'b1, r);
    chk(r, 1);
    summarize();
  end
  initial begin
    #100us;
    nErrors++;
    summarize();
  end
endmodule
`default_nettype wire
